// ### core/irq_control_top.sv
// Contract
// R1: global enable gates every interrupt source (code gates core_irq_req only; irq_out ignores it)
// R2: peripheral enable gates all peripheral interrupts
// R3: bit 5 enables timer overflow interrupt
// R4: bit 4 enables external pin interrupt
// R5: bit 3 enables pin change interrupt
// R6: timer overflow sets bit 2 flag
// R7: external pin event sets bit 1 flag
// R8: bit 0 shows any pin change flag
// R9: summary flag read-only, clears with bank
// R10: flags set regardless of enables
// R11: software clears flags before enabling
// R12: request is global and any enabled source
//
// Purpose: core interrupt control register behind an axi4-lite slave
// Assumes: one write and one read at a time, 32-bit data
// Notes: event status, mask and one level interrupt output
`timescale 1ns/10ps
`include "irq_ctl_defs.svh"
module irq_control_top #(
	parameter int BANK_W = 8,
	parameter int PERIPH_W = 4
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic timer_overflow_evt,
	input wire logic ext_pin_evt,
	input wire logic [BANK_W-1:0] pin_change_flag_bank,
	input wire logic [PERIPH_W-1:0] periph_irq_req,
	output logic core_irq_req,
	output logic irq_out,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import irq_ctl_pkg::*;

	if (PERIPH_W < 1) begin : g_bad_periph_w
		$error("PERIPH_W must be at least 1");
	end

	function automatic logic is_reg(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction : is_reg

	logic [7:0] ctrl_ff;
	logic [2:0] evt_sts_ff;
	logic [2:0] evt_mask_ff;
	logic [3:0] awaddr_ff;
	logic aw_have_ff;
	logic [31:0] wdata_ff;
	logic w_lane0_ff;
	logic w_have_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic irq_ff;
	logic req_ff;
	evt_s flags;
	evt_s evt_now;
	logic pcf_d_ff;
	logic wr_fire;
	logic ctrl_wr;
	logic sts_wr;
	logic mask_wr;

	// write address and data captured in either order
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready = !w_have_ff && !bvalid_ff;
	assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
	assign ctrl_wr = wr_fire && w_lane0_ff && is_reg(awaddr_ff, `OFS_IRQ_CONTROL);
	assign sts_wr = wr_fire && w_lane0_ff && is_reg(awaddr_ff, `OFS_EVT_STATUS);
	assign mask_wr = wr_fire && w_lane0_ff && is_reg(awaddr_ff, `OFS_EVT_MASK);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_have_ff <= 1'b0;
			awaddr_ff <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			w_have_ff <= 1'b0;
			wdata_ff <= 32'h0;
			w_lane0_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			w_lane0_ff <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (is_reg(awaddr_ff, `OFS_IRQ_CONTROL) || is_reg(awaddr_ff, `OFS_EVT_STATUS)
				|| is_reg(awaddr_ff, `OFS_EVT_MASK)) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// enables and global bits, software owned
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_ff <= `CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_ff <= wdata_ff[7:0] & `CTRL_WMASK;
		end
	end

	irq_sources #(
		.BANK_W(BANK_W)
	) u_sources (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.timer_overflow_evt(timer_overflow_evt),
		.ext_pin_evt(ext_pin_evt),
		.pin_change_flag_bank(pin_change_flag_bank),
		.wr_en(ctrl_wr),
		.wr_val({wdata_ff[`BIT_TOF], wdata_ff[`BIT_EXF]}),
		.timer_overflow_flag(flags.timer_ovf),
		.ext_pin_irq_flag(flags.ext_pin),
		.pin_change_summary_flag(flags.pin_change)
	);

	// rising edge of summary flag counts as an event
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pcf_d_ff <= 1'b0;
		end else begin
			pcf_d_ff <= flags.pin_change;
		end
	end
	assign evt_now.timer_ovf = timer_overflow_evt;
	assign evt_now.ext_pin = ext_pin_evt;
	assign evt_now.pin_change = flags.pin_change && !pcf_d_ff;

	// sticky event status, write one to clear, set wins
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			evt_sts_ff <= `EVT_RESET;
		end else begin
			evt_sts_ff <= (evt_sts_ff & ~(sts_wr ? wdata_ff[2:0] : 3'h0)) | evt_now;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			evt_mask_ff <= `EVT_RESET;
		end else if (mask_wr) begin
			evt_mask_ff <= wdata_ff[2:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(evt_sts_ff & evt_mask_ff);
		end
	end
	assign irq_out = irq_ff;

	// request to the core
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			req_ff <= 1'b0;
		end else begin
			req_ff <= ctrl_ff[`BIT_GIE] && ( // [R1] [R12]
				(flags.timer_ovf && ctrl_ff[`BIT_TOIE]) || // [R3]
				(flags.ext_pin && ctrl_ff[`BIT_EXIE]) || // [R4]
				(flags.pin_change && ctrl_ff[`BIT_PCIE]) || // [R5]
				((|periph_irq_req) && ctrl_ff[`BIT_PERIPHERAL_GROUP_IRQ_ENABLE])); // [R2]
		end
	end
	assign core_irq_req = req_ff;

	// read channel
	assign s_axi_arready = !rvalid_ff;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= `RESP_OKAY;
			rdata_ff <= 32'h0;
			if (is_reg(s_axi_araddr, `OFS_IRQ_CONTROL)) begin
				rdata_ff <= {24'h0, ctrl_ff[7:3], flags.timer_ovf, flags.ext_pin,
					flags.pin_change};
			end else if (is_reg(s_axi_araddr, `OFS_EVT_STATUS)) begin
				rdata_ff <= {29'h0, evt_sts_ff};
			end else if (is_reg(s_axi_araddr, `OFS_EVT_MASK)) begin
				rdata_ff <= {29'h0, evt_mask_ff};
			end else begin
				rresp_ff <= `RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule : irq_control_top

// ### core/irq_ctl_defs.svh
// Purpose: constants for the core interrupt control block
// Assumes: 32-bit axi4-lite data, word aligned registers
// Notes: offsets are byte addresses
`ifndef IRQ_CTL_DEFS_SVH
`define IRQ_CTL_DEFS_SVH
`define OFS_IRQ_CONTROL 4'h0
`define OFS_EVT_STATUS 4'h4
`define OFS_EVT_MASK 4'h8
`define BIT_GIE 7
`define BIT_PERIPHERAL_GROUP_IRQ_ENABLE 6
`define BIT_TOIE 5
`define BIT_EXIE 4
`define BIT_PCIE 3
`define BIT_TOF 2
`define BIT_EXF 1
`define BIT_PCF 0
`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'hfe
`define EVT_RESET 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### core/irq_ctl_pkg.sv
// Purpose: shared types for the core interrupt control block
// Assumes: nothing beyond the defs header
// Notes: events are timer overflow, external pin, pin change
package irq_ctl_pkg;
	typedef struct packed {
		logic timer_ovf;
		logic ext_pin;
		logic pin_change;
	} evt_s;
	typedef enum logic [1:0] {
		W_IDLE,
		W_RESP
	} wr_state_e;
endpackage : irq_ctl_pkg

// ### core/irq_sources.sv
// Purpose: timer and external pin flag latches, pin change summary
// Assumes: events are one-cycle pulses, synchronous to sys_clk
// Notes: set wins over a same-cycle software clear
`timescale 1ns/10ps
module irq_sources #(
	parameter int BANK_W = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic timer_overflow_evt,
	input wire logic ext_pin_evt,
	input wire logic [BANK_W-1:0] pin_change_flag_bank,
	input wire logic wr_en,
	input wire logic [1:0] wr_val,
	output logic timer_overflow_flag,
	output logic ext_pin_irq_flag,
	output logic pin_change_summary_flag
);
	if (BANK_W < 1) begin : g_bad_bank_w
		$error("BANK_W must be at least 1");
	end
	logic tof_ff;
	logic exf_ff;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tof_ff <= 1'b0;
		end else if (timer_overflow_evt) begin
			tof_ff <= 1'b1; // [R6] [R10]
		end else if (wr_en) begin
			tof_ff <= wr_val[1];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			exf_ff <= 1'b0;
		end else if (ext_pin_evt) begin
			exf_ff <= 1'b1; // [R7] [R10]
		end else if (wr_en) begin
			exf_ff <= wr_val[0];
		end
	end
	assign timer_overflow_flag = tof_ff;
	assign ext_pin_irq_flag = exf_ff;
	assign pin_change_summary_flag = |pin_change_flag_bank; // [R8] [R9]
endmodule : irq_sources

// ### verif/irq_control_props.sv
// Purpose: bus and flag checks
// Assumes: one clock
// Notes: bound from tb_top
`timescale 1ns/10ps
module irq_control_props #(
	parameter int BANK_W = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [BANK_W-1:0] pin_change_flag_bank,
	input wire logic irq_out,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic ar_go = s_axi_arvalid && s_axi_arready;
	wire logic w_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("awready");
	a_rd_lat: assert property (ar_go |=> s_axi_rvalid) else $error("late read");
	a_wr_lat: assert property (w_go |-> ##2 s_axi_bvalid) else $error("late write");
	a_bad_addr: assert property (ar_go && !(s_axi_araddr inside {4'h0, 4'h4, 4'h8}) |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
	a_pc_summary: assert property (ar_go && s_axi_araddr == 4'h0 &&
		$stable(pin_change_flag_bank) |=> s_axi_rdata[0] == |$past(pin_change_flag_bank))
		else $error("summary flag");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_bad: cover property (ar_go && s_axi_araddr == 4'hc);
	c_irq: cover property ($rose(irq_out));
endmodule : irq_control_props

// ### verif/src_model.sv
// Purpose: timer and external pin sources
// Assumes: bench levels on tmr_run, ext_go
// Notes: overflow once per 256 counts
`timescale 1ns/10ps
module src_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tmr_run,
	input wire logic ext_go,
	output logic timer_overflow_evt,
	output logic ext_pin_evt
);
	logic [7:0] timer_count_ff;
	logic ext_go_ff;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) timer_count_ff <= 8'h00;
		else if (tmr_run) timer_count_ff <= timer_count_ff + 8'h01;
	end
	always_ff @(posedge sys_clk) begin
		timer_overflow_evt <= !sys_rst && tmr_run && timer_count_ff == 8'hff;
		ext_go_ff <= ext_go;
		ext_pin_evt <= !sys_rst && ext_go && !ext_go_ff;
	end
endmodule : src_model

// ### verif/tb_top.sv
// Purpose: register level tests
// Assumes: axi4-lite master, one access at a time
// Notes: timer and external pin sources from src_model
`timescale 1ns/10ps
`include "irq_ctl_defs.svh"
module tb_top;
	logic sys_clk = 0, sys_rst = 1, tmr_run = 0, ext_go = 0;
	logic timer_overflow_evt, ext_pin_evt, core_irq_req, irq_out;
	logic [7:0] pin_change_flag_bank = 0;
	logic [3:0] periph_irq_req = 0, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [11:0] cases [11] = '{12'h024, 12'h4a4, 12'h0a0, 12'h084, 12'h492, 12'h082,
		12'h588, 12'h180, 12'h6c0, 12'h280, 12'h240};
	int miscompares = 0, n_compared = 0, cyc = 0;
	irq_control_top irq_control_top_inst (.*);
	src_model src_model_inst (.*);
	initial forever #50 sys_clk = ~sys_clk;
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic w(input logic [3:0] a, input logic [7:0] d);
		bit ad = 0;
		bit wd = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd)) begin
			@(posedge sys_clk);
			if (!ad && s_axi_awready) begin
				s_axi_awvalid <= 0;
				ad = 1;
			end
			if (!wd && s_axi_wready) begin
				s_axi_wvalid <= 0;
				wd = 1;
			end
		end
		do @(posedge sys_clk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge sys_clk);
	endtask : w
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge sys_clk);
	endtask : rd
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 0;
		@(posedge sys_clk);
		rd(4'h0);
		chk(rd_data, 32'h0);
		ext_go <= 1;
		tmr_run <= 1;
		repeat (260) @(posedge sys_clk);
		tmr_run <= 0;
		ext_go <= 0;
		chk(core_irq_req, 1'b0);
		rd(4'h0);
		chk(rd_data, 32'h6);
		w(4'h0, 8'h00);
		w(4'h0, 8'hff);
		rd(4'h0);
		chk(rd_data, 32'hfe);
		foreach (cases[i]) begin
			pin_change_flag_bank <= {7'h0, cases[i][8]};
			periph_irq_req <= {3'h0, cases[i][9]};
			w(4'h0, cases[i][7:0]);
			repeat (2) @(posedge sys_clk);
			chk(core_irq_req, cases[i][10]);
		end
		pin_change_flag_bank <= 8'h10;
		w(4'h0, 8'h00);
		rd(4'h0);
		chk(rd_data, 32'h1);
		pin_change_flag_bank <= 8'h00;
		repeat (2) @(posedge sys_clk);
		rd(4'h0);
		chk(rd_data, 32'h0);
		w(4'h4, 8'h07);
		chk(resp, `RESP_OKAY);
		ext_go <= 1;
		repeat (3) @(posedge sys_clk);
		rd(4'h4);
		chk(rd_data, 32'h2);
		chk(irq_out, 1'b0);
		w(4'h8, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk(irq_out, 1'b1);
		w(4'h4, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk(irq_out, 1'b0);
		rd(4'hc);
		chk({rd_data[29:0], resp}, {30'h0, `RESP_SLVERR});
		w(4'hc, 8'h00);
		chk(resp, `RESP_SLVERR);
		report_and_stop();
	end
endmodule : tb_top
bind irq_control_top irq_control_props #(.BANK_W(BANK_W)) irq_control_props_inst (.*);
